// ---- verilog/bkp_cfg.svh ----
`ifndef BKP_CFG_SVH
`define BKP_CFG_SVH
`define WORD_COUNT 10
`define WORD_WIDTH 16
`define WORD_RESET 16'h0000
`define DIV_HALF 6'h1F
`define CAL_BLOCK_BITS 20
`define CAL_WIDTH 7
`endif

// ---- verilog/bkp_pkg.sv ----
package bkp_pkg;
  // Calibration slot state
  typedef enum logic [1:0] {cal_idle, cal_skip, cal_insert} cal_state_e;
  typedef logic [3:0] word_idx_t;
endpackage

// ---- verilog/backup_domain_tamper_calib.sv ----
`timescale 1ns/1ps
`include "bkp_cfg.svh"
module backup_domain_tamper_calib
  import bkp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Backup domain reset, sync high
  input wire logic ce, // Clock enable
  input wire logic backup_write_enable, // Write gate
  input wire logic wr_en, // Data word write strobe
  input wire word_idx_t wr_idx, // Data word index
  input wire logic [15:0] wr_data, // Data word value
  input wire word_idx_t rd_idx, // Read index
  output logic [15:0] rd_data, // Registered read data
  input wire logic rtc_tick, // RTC clock pulse (one cycle)
  input wire logic tamper_pin, // Async tamper input
  input wire logic tamper_active_level, // 0 high, 1 low
  input wire logic tamper_detect_enable, // Detection enable
  input wire logic tamper_int_enable, // Interrupt enable
  input wire logic tamper_flag_clear, // Clear event flag
  output logic tamper_event_flag, // Sticky event flag
  output logic tamper_irq, // Interrupt level
  input wire logic cal_clock_out_enable, // Calibration output enable
  input wire logic cal_out_select, // 0 div64, 1 raw
  input wire logic cal_direction, // 0 slow, 1 fast
  input wire logic [6:0] cal_value, // Pulses per block
  output logic cal_clk_out, // Calibration output pin
  output logic cal_clk_out_en, // Pin output enable
  output logic rtc_cal_tick // Calibrated RTC tick
);

  // ----------------------------------------
  // Storage and tamper path
  // ----------------------------------------
  logic [15:0] word_mem [`WORD_COUNT]; // Retained words
  logic [1:0] pin_sync; // Synchroniser
  logic pin_act_d; // Previous active state
  logic pin_active; // Level-normalised pin
  logic tamper_hit; // Detected event
  logic [`CAL_BLOCK_BITS-1:0] blk_cnt; // Block pulse counter
  logic [5:0] div_cnt; // Divider counter
  logic div_clk; // Divided clock
  logic [6:0] cal_done; // Adjusted pulses this block
  cal_state_e cal_state; // Adjust state
  logic next_flag; // Flag value after this edge

  // Index names one of the retained words
  function automatic logic idx_in_range(input word_idx_t idx);
    return idx < 4'(`WORD_COUNT);
  endfunction

  assign pin_active = pin_sync[1] ^ tamper_active_level;
  // edge AND enable; via pin_act_d reset low while disabled
  assign tamper_hit = tamper_detect_enable & pin_active & ~pin_act_d;
  // Set wins over a clear in the same cycle
  assign next_flag = tamper_hit | (tamper_event_flag & ~tamper_flag_clear);

  // Two-flop synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_sync <= 2'h0;
    else if (ce)
      pin_sync <= {pin_sync[0], tamper_pin};
  end

  // Edge memory, cleared while disabled
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_act_d <= 1'h0;
    else if (ce)
      pin_act_d <= tamper_detect_enable & pin_active;
  end

  // Event flag and interrupt
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tamper_event_flag <= 1'h0;
      tamper_irq <= 1'h0;
    end
    else if (ce)
    begin
      tamper_event_flag <= next_flag;
      tamper_irq <= tamper_int_enable & next_flag;
    end
  end

  // Retained words; backup domain reset and tamper both wipe them
  genvar gi;
  generate
    for (gi = 0; gi < `WORD_COUNT; gi++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (rst)
          word_mem[gi] <= `WORD_RESET;
        else if (ce)
        begin
          if (tamper_hit)
            word_mem[gi] <= `WORD_RESET;
          else if (wr_en && backup_write_enable && idx_in_range(wr_idx) && wr_idx == 4'(gi))
            word_mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Read port
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= 16'h0000;
    else if (ce)
      // Unused indexes read as zero
      rd_data <= idx_in_range(rd_idx) ? word_mem[rd_idx] : `WORD_RESET;
  end

  // ----------------------------------------
  // Calibration
  // ----------------------------------------
  // Divide-by-64 square wave
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt <= 6'h00;
      div_clk <= 1'h0;
    end
    else if (ce && rtc_tick)
    begin
      div_cnt <= (div_cnt == `DIV_HALF) ? 6'h00 : div_cnt + 6'h01;
      if (div_cnt == `DIV_HALF)
        div_clk <= ~div_clk;
    end
  end

  // Output pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_clk_out <= 1'h0;
      cal_clk_out_en <= 1'h0;
    end
    else if (ce)
    begin
      cal_clk_out_en <= cal_clock_out_enable;
      cal_clk_out <= cal_clock_out_enable & (cal_out_select ? rtc_tick : div_clk);
    end
  end

  // Skip/insert engine over 2^20 pulse blocks
  // Ticks must be two or more cycles apart: the
  // insert and skip slots take one cycle each
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      blk_cnt <= '0;
      cal_done <= 7'h00;
      cal_state <= cal_idle;
      rtc_cal_tick <= 1'h0;
    end
    else if (ce)
    begin
      rtc_cal_tick <= 1'h0;
      case (cal_state)
        cal_idle:
        begin
          if (rtc_tick)
          begin
            // Count pulses within the block
            blk_cnt <= blk_cnt + {{(`CAL_BLOCK_BITS-1){1'b0}}, 1'b1};
            // Last pulse of block: restart count
            if (blk_cnt == '1)
              cal_done <= 7'h00;
            if (cal_done < cal_value && blk_cnt != '1)
            begin
              cal_done <= cal_done + 7'h01;
              if (cal_direction)
              begin
                rtc_cal_tick <= 1'h1;
                cal_state <= cal_insert;
              end
              else
                cal_state <= cal_skip;
            end
            // Pulse passes unchanged
            else
              rtc_cal_tick <= 1'h1;
          end
        end
        // Extra pulse for speed-up
        cal_insert:
        begin
          rtc_cal_tick <= 1'h1;
          cal_state <= cal_idle;
        end
        // Swallowed pulse, no output
        cal_skip:
          cal_state <= cal_idle;
        // Unused code back to idle
        default:
          cal_state <= cal_idle;
      endcase
    end
  end
endmodule

// ---- verification/bkp_chk.sv ----
`timescale 1ns/1ps
// ----
// Tamper, read and reset checks
// ----
module bkp_chk
  import bkp_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Clock enable
  input wire word_idx_t rd_idx, // Index
  input wire logic [15:0] rd_data, // Data
  input wire logic tamper_detect_enable, // Enable
  input wire logic tamper_int_enable, // Irq on
  input wire logic tamper_flag_clear, // Clear
  input wire logic tamper_event_flag, // Flag
  input wire logic tamper_irq // Irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_en; !tamper_detect_enable [*2] ##0 !tamper_event_flag |=> !tamper_event_flag; endproperty
  a_en: assert property (p_en) else $error("flag while off");
  property p_keep; tamper_event_flag && !tamper_flag_clear |=> tamper_event_flag; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_wipe; $rose(tamper_event_flag) && ce |=> rd_data == 16'h0000; endproperty
  a_wipe: assert property (p_wipe) else $error("no wipe");
  property p_ion; tamper_int_enable && tamper_event_flag && !tamper_flag_clear && ce |=> tamper_irq; endproperty
  a_ion: assert property (p_ion) else $error("irq missing");
  property p_ioff; !tamper_int_enable && ce |=> !tamper_irq; endproperty
  a_ioff: assert property (p_ioff) else $error("irq masked");
  property p_iflag; tamper_irq |-> tamper_event_flag; endproperty
  a_iflag: assert property (p_iflag) else $error("irq no flag");
  property p_idx; rd_idx > 4'h9 && ce |=> rd_data == 16'h0000; endproperty
  a_idx: assert property (p_idx) else $error("word beyond ten");
  property p_rst; $fell(rst) |-> rd_data == 16'h0000 && !tamper_event_flag && !tamper_irq; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  c_flag: cover property ($rose(tamper_event_flag));
  c_irq: cover property (tamper_irq);
  c_idx: cover property (rd_idx > 4'h9);
endmodule
bind backup_domain_tamper_calib bkp_chk chk (.clk, .rst, .ce, .rd_idx, .rd_data, .tamper_detect_enable,
  .tamper_int_enable, .tamper_flag_clear, .tamper_event_flag, .tamper_irq);

// ---- verification/pad_model.sv ----
`timescale 1ns/1ps
module pad_model (
  input wire logic clk, // Clock
  input wire logic lvl, // Level asked
  input wire logic cal_clk_out, // Cal pin
  input wire logic oe, // Cal pin driven
  output logic tamper_pin, // Tamper pin
  output int rises // Cal rises
);
  logic prev = 1'b0; // Last cal level
  assign tamper_pin = lvl;
  // Count cal pin rises
  always @(posedge clk)
  begin
    prev <= cal_clk_out;
    rises <= rises + int'(oe && cal_clk_out && !prev);
  end
endmodule

// ---- verification/tb_backup_domain_tamper_calib.sv ----
`timescale 1ns/1ps
`define CHK(n,x,s) begin e = x; cmp_count++; if (e !== s) begin bad_count++; $display("mismatch %s %h %h", n, e, s); end end
module tb_backup_domain_tamper_calib;
  import bkp_pkg::*;
  // ----
  // Stimulus
  // ----
  logic clk = 0, rst = 1, bwe = 0, we = 0, tk = 0, pl = 0, al = 0, en = 0, ie = 0, clr = 0, sel = 0, dir = 0; // Drives
  logic rq = 0, rq1 = 0, fl, irq, co, ct, tp; // Read note, outputs
  logic ce = 1, oe = 1, coe; // Enables, pin enable seen
  word_idx_t wi = 0, ri = 0; // Indexes
  logic [15:0] wd = 0, rd, v; // Data
  logic [6:0] cv = 0; // Cal value
  logic [31:0] e, q[$]; // Notes
  int bad_count, cmp_count, rises, nct, r0; // Counters
  backup_domain_tamper_calib uut (.clk, .rst, .ce(ce), .backup_write_enable(bwe), .wr_en(we), .wr_idx(wi),
    .wr_data(wd), .rd_idx(ri), .rd_data(rd), .rtc_tick(tk), .tamper_pin(tp), .tamper_active_level(al),
    .tamper_detect_enable(en), .tamper_int_enable(ie), .tamper_flag_clear(clr), .tamper_event_flag(fl),
    .tamper_irq(irq), .cal_clock_out_enable(oe), .cal_out_select(sel), .cal_direction(dir), .cal_value(cv),
    .cal_clk_out(co), .cal_clk_out_en(coe), .rtc_cal_tick(ct));
  pad_model pad (.clk, .lvl(pl), .cal_clk_out(co), .oe(coe), .tamper_pin(tp), .rises);
  // Clock
  initial forever #4 clk = ~clk;
  // Oldest note against outputs
  always @(posedge clk)
  begin
    nct <= nct + int'(ct);
    rq1 <= rq;
    if (rq1) `CHK("out", q.pop_front(), {fl, irq, rd})
  end
  task tick(input int n); repeat (n) @(posedge clk); #1; endtask
  task look(input int a, input logic [31:0] x); ri = 4'(a); rq = 1; q.push_back(x); tick(1); rq = 0; tick(1); endtask
  task wr; we = 1; for (int k = 0; k < 16; k++) begin wi = 4'(k); wd = v ^ 16'(k); tick(1); end we = 0; endtask
  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    void'($urandom(37164));
    tick(16);
    rst = 0;
    // Calibration setups, each from reset
    for (int m = 0; m < 4; m++)
    begin
      cv = (m == 2) ? 7'h00 : 7'(1 + $urandom % 127);
      dir = (m == 1);
      sel = (m != 2);
      oe = (m != 3);
      if (m > 0)
      begin
        rst = 1;
        tick(1);
        rst = 0;
      end
      r0 = rises;
      nct = 0;
      repeat (256) begin tk = 1; tick(1); tk = 0; tick(1); end
      tick(2);
      `CHK("cal", 256 + (dir ? int'(cv) : -int'(cv)), nct)
      `CHK("pin", (m == 3) ? 0 : (m == 2) ? 4 : 256, rises - r0)
      `CHK("pin_en", oe, coe)
    end
    // Words, write gate and tamper
    for (int k = 0; k < 16; k++) look(k, 0);
    v = 16'($urandom);
    wr();
    look(3, 0);
    bwe = 1;
    ce = 0;
    wr();
    ce = 1;
    look(6, 0);
    wr();
    for (int k = 0; k < 12; k++) look(k, (k < 10) ? v ^ k : 0);
    pl = 1;
    tick(4);
    pl = 0;
    tick(4);
    look(2, v ^ 2);
    ie = 1;
    en = 1;
    tick(2);
    pl = 1;
    tick(5);
    look(5, 32'h30000);
    clr = 1;
    tick(1);
    {clr, en, ie, al, pl} = 5'b00010;
    wr();
    look(4, v ^ 4);
    en = 1;
    tick(5);
    look(0, 32'h20000);
    summarize();
  end
endmodule
